// ### core/rap_pkg.sv
package rap_pkg;
  // ------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00; // Boot state, read only
  localparam logic [7:0] OFS_CTRL   = 8'h04; // Reboot strobe
  localparam logic [7:0] OFS_LEVEL  = 8'h08; // Programming level
  localparam logic [7:0] OFS_GUARD  = 8'h0c; // Retest guard byte
  localparam logic [7:0] OFS_PRIME  = 8'h10; // Primary guard byte
  localparam logic [7:0] OFS_SADDR  = 8'h14; // Store address
  localparam logic [7:0] OFS_SDATA  = 8'h18; // Store data
  localparam logic [7:0] OFS_CRCCMD = 8'h1c; // Checksum command
  localparam logic [7:0] OFS_CRC    = 8'h20; // Checksum result
  localparam logic [7:0] OFS_EEP    = 8'h24; // EEPROM data
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_STORE_LOCK = 7; // Main-store lock on retest
  localparam int BIT_EEP_LOCK   = 6; // EEPROM lock on retest
  localparam int BIT_RAM_WIPE   = 5; // RAM wipe on retest
  localparam int BIT_PORT_KILL  = 0; // Primary byte: port kill
  localparam int BIT_REBOOT     = 0; // Ctrl: rerun boot
  localparam logic [7:0] GUARD_MASK = 8'he0; // Writable guard bits
  // ------------------------------------------------------------
  // Reset values and codes
  // ------------------------------------------------------------
  localparam logic [7:0] GUARD_RST    = 8'h00;
  localparam logic [1:0] CRC_FACTORY  = 2'h1; // Checksum commands
  localparam logic [1:0] CRC_USER     = 2'h2;
  localparam logic [3:0] RETEST_SEQ   = 4'hb; // Pin pattern, oldest first
  localparam int         SEQ_LEN      = 4;
  localparam int         IRAM_KEEP    = 8;    // Register bank 0
  localparam int         IRAM_BYTES   = 256;
  localparam int         TAIL_BYTES   = 64;   // Reserved store tail
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS    = 25;     // 40 MHz
  localparam int TICK_NS   = 1000;   // Pin sample period
  localparam int TICK_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_NS   = 2000;   // Region load time
  localparam int LOAD_CYC  = (LOAD_NS + CLK_NS - 1) / CLK_NS;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_FACTORY, LVL_USER, LVL_RUN
  } rap_level_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WINDOW, ST_LOAD, ST_WRAM, ST_WIRAM, ST_LOCK, ST_DONE
  } rap_state_t;
endpackage

// ### core/rap_crc_if.sv
`timescale 1ns/1ps
// Byte stream into the checksum engine
interface rap_crc_if;
  logic        clr;  // Restart checksum
  logic        vld;  // Byte valid this cycle
  logic [7:0]  data; // Byte value
  logic [31:0] crc;  // Running result, final form
  modport src (output clr, output vld, output data, input crc);
  modport eng (input clr, input vld, input data, output crc);
endinterface

// ### core/rap_crc32.sv
`timescale 1ns/1ps
module rap_crc32
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  rap_crc_if.eng    crc_if
);
  // ------------------------------------------------------------
  // Reflected CRC32, one byte a cycle
  // ------------------------------------------------------------
  localparam logic [31:0] POLY = 32'hedb88320;
  localparam logic [31:0] INIT = 32'hffffffff;

  logic [31:0] state; // Running remainder

  // Bitwise step over one byte
  function automatic logic [31:0] step(input logic [31:0] c,
                                       input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ POLY) : (r >> 1);
    return r;
  endfunction

  // Remainder update
  always_ff @(posedge clk_i)
  begin
    if (rst_i || crc_if.clr)
      state <= INIT;
    else if (crc_if.vld)
      state <= step(state, crc_if.data);
  end

  // Final inversion
  assign crc_if.crc = ~state;
endmodule // rap_crc32

// ### core/rap_retest_guard.sv
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
// Function
// - User level appends blocks while space remains
// - Run level closes the debug port except on retest entry
// - Pin sequence at boot of an unkilled run part loads factory only
// - Guard actions finish before port opens
// - Guard flags ignored below run level
// - Guard choices fixed once part runs
// - Port kill: never open, flags ignored
// - RAM wipe zeroes code RAM, spares factory
// - RAM wipe clears IRAM above bank 0
// - EEPROM lock flag sets EEPROM lock
// - Locked EEPROM reads zero, ignores writes
// - Store lock flag locks store at boot end
// - Locked store still checksums factory region
// - Locked store still checksums user portion
// - Locked store still reads reserved tail
// - Locked store refuses all other access
// - Guard bits set once, cleared only by reset
// - Guard bits 7,6,5: store, EEPROM, wipe
module rap_retest_guard
#(
  parameter int STORE_BYTES = 256,  // Main store size
  parameter int FACT_BYTES  = 32,   // Factory region at store start
  parameter int RAM_BYTES   = 4608, // Unified code/data RAM
  parameter int RAM_FACT    = 256   // Factory region at RAM end
)
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 retest_pin_i,
  input  wire logic [7:0]           eep_rdata_i,
  output logic                      eep_wr_o,
  output logic      [7:0]           eep_wdata_o,
  output logic                      two_wire_debug_port_o,
  output logic                      load_user_o,
  output logic                      ram_wipe_we_o,
  output logic                      ram_wipe_iram_o,
  output logic      [12:0]          ram_wipe_addr_o,
  output logic                      eeprom_lock_o,
  output logic                      store_lock_o,
  output logic                      boot_done_o,
  output rap_pkg::rap_state_t       boot_state_o
);
  import rap_pkg::*;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (STORE_BYTES < FACT_BYTES + TAIL_BYTES + 1 || STORE_BYTES > 65536
      || RAM_FACT >= RAM_BYTES || RAM_BYTES > 8192)
    $error("rap_retest_guard: unsupported sizes");

  localparam int AW = $clog2(STORE_BYTES);
  localparam logic [AW:0] FACT_END  = (AW+1)'(FACT_BYTES);
  localparam logic [AW:0] TAIL_BASE = (AW+1)'(STORE_BYTES - TAIL_BYTES);
  localparam logic [AW:0] STORE_END = (AW+1)'(STORE_BYTES);
  localparam logic [12:0] WIPE_LAST = 13'(RAM_BYTES - RAM_FACT - 1);
  localparam logic [12:0] IRAM_LAST = 13'(IRAM_BYTES - 1);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0]  store [STORE_BYTES]; // Main non-volatile store
  rap_level_t  level;               // Programming level
  logic [7:0]  guard;               // Retest guard byte
  logic        kill;                // Primary guard: port kill
  logic [AW:0] append_ptr;          // Next free user byte
  logic [AW:0] saddr;               // Software store address

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic req;  // New request this cycle
  logic wr;   // New write with low byte lane
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = req && wb_we_i && wb_sel_i[0];

  // Reserved tail, readable under the store lock
  function automatic logic tail_ok(input logic [AW:0] a);
    return a >= TAIL_BASE && a < STORE_END;
  endfunction

  logic [31:0] crc_val; // Latest checksum
  logic        crc_busy;
  rap_state_t  state;

  // Read mux
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    case (a)
      OFS_STATUS: rd_word = {22'h0, crc_busy, store_lock_o,
                             eeprom_lock_o, two_wire_debug_port_o,
                             boot_done_o, 2'(level), 3'(state)};
      OFS_LEVEL:  rd_word = {30'h0, 2'(level)};
      OFS_SADDR:  rd_word = 32'(saddr);
      OFS_SDATA:  rd_word = (!store_lock_o || tail_ok(saddr))
                            && saddr < STORE_END
                            ? {24'h000000, store[saddr[AW-1:0]]}
                            : 32'h00000000;
      OFS_CRC:    rd_word = crc_val;
      OFS_EEP:    rd_word = eeprom_lock_o ? 32'h00000000
                            : {24'h000000, eep_rdata_i};
      default:    rd_word = 32'h00000000; // Guard bytes read as zero
    endcase
  endfunction

  // Classic single-cycle answer, one wait state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= req && !wb_we_i ? rd_word(wb_adr_i) : 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // Programming level and guard bytes
  // ------------------------------------------------------------
  // Level only moves upward one step at a time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      level <= LVL_FACTORY;
    else if (wr && wb_adr_i == OFS_LEVEL && level != LVL_RUN
             && wb_dat_i[1:0] == 2'(level) + 2'h1)
      level <= rap_level_t'(wb_dat_i[1:0]);
  end

  // Guard bits only ever set, and only before run level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      guard <= GUARD_RST;
      kill  <= 1'b0;
    end
    else if (wr && level != LVL_RUN)
    begin
      if (wb_adr_i == OFS_GUARD)
        guard <= guard | (wb_dat_i[7:0] & GUARD_MASK);
      if (wb_adr_i == OFS_PRIME && wb_dat_i[BIT_PORT_KILL])
        kill <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Main store access
  // ------------------------------------------------------------
  // Address register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      saddr <= '0;
    else if (wr && wb_adr_i == OFS_SADDR)
      saddr <= wb_dat_i[AW:0];
  end

  // Factory writes anywhere, user level appends, run is read only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      append_ptr <= FACT_END;
    else if (wr && wb_adr_i == OFS_SDATA && !store_lock_o)
    begin
      if (level == LVL_FACTORY && saddr < STORE_END)
        store[saddr[AW-1:0]] <= wb_dat_i[7:0];
      else if (level == LVL_USER && append_ptr < TAIL_BASE)
      begin
        store[append_ptr[AW-1:0]] <= wb_dat_i[7:0];
        append_ptr <= append_ptr + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Checksum walker, allowed under the store lock
  // ------------------------------------------------------------
  rap_crc_if   crc_bus ();
  logic [AW:0] crc_addr; // Byte being fed
  logic [AW:0] crc_stop; // One past last byte

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      crc_busy <= 1'b0;
      crc_addr <= '0;
      crc_stop <= '0;
    end
    else if (!crc_busy && wr && wb_adr_i == OFS_CRCCMD)
    begin
      if (wb_dat_i[1:0] == CRC_FACTORY)
      begin
        crc_busy <= 1'b1;
        crc_addr <= '0;
        crc_stop <= FACT_END;
      end
      else if (wb_dat_i[1:0] == CRC_USER)
      begin
        crc_busy <= 1'b1;
        crc_addr <= FACT_END;
        crc_stop <= TAIL_BASE;
      end
    end
    else if (crc_busy)
    begin
      crc_addr <= crc_addr + 1'b1;
      if (crc_addr + 1'b1 == crc_stop)
        crc_busy <= 1'b0;
    end
  end

  assign crc_bus.clr  = !crc_busy && wr && wb_adr_i == OFS_CRCCMD;
  assign crc_bus.vld  = crc_busy;
  assign crc_bus.data = store[crc_addr[AW-1:0]];

  rap_crc32 u_crc
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .crc_if (crc_bus)
  );

  // Result readable only once the walk has ended
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      crc_val <= 32'h00000000;
    else if (!crc_busy)
      crc_val <= crc_bus.crc;
  end

  // ------------------------------------------------------------
  // EEPROM gate
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      eep_wr_o    <= 1'b0;
      eep_wdata_o <= 8'h00;
    end
    else
    begin
      // Writes vanish while locked
      eep_wr_o <= wr && wb_adr_i == OFS_EEP && !eeprom_lock_o;
      if (wr && wb_adr_i == OFS_EEP && !eeprom_lock_o)
        eep_wdata_o <= wb_dat_i[7:0];
    end
  end

  // ------------------------------------------------------------
  // Retest pin sampling
  // ------------------------------------------------------------
  logic                 pin_s1;   // First synchroniser stage
  logic                 pin_s2;   // Second stage
  logic [SEQ_LEN-1:0]   pin_hist; // Sampled pattern
  logic [$clog2(TICK_CYC)-1:0] div;
  logic                 tick;     // Sample enable
  logic [2:0]           nseen;    // Samples taken

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end
    else
    begin
      pin_s1 <= retest_pin_i;
      pin_s2 <= pin_s1;
    end
  end

  // Sample divider
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state != ST_WINDOW)
    begin
      div  <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= div == ($bits(div))'(TICK_CYC - 1);
      div  <= div == ($bits(div))'(TICK_CYC - 1) ? '0 : div + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Boot sequencer
  // ------------------------------------------------------------
  logic        reboot;   // Software warm boot
  logic        retest;   // Retest entry recognised
  logic [12:0] wcnt;     // Wipe address or load timer
  logic        armed;    // Guard flags in force
  assign reboot = wr && wb_adr_i == OFS_CTRL && wb_dat_i[BIT_REBOOT];
  // Flags count only for a run part not killed
  assign armed  = level == LVL_RUN && !kill;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || reboot)
    begin
      state    <= ST_WINDOW;
      pin_hist <= '0;
      nseen    <= 3'h0;
      wcnt     <= 13'h0000;
      retest   <= 1'b0;
    end
    else
    begin
      case (state)
        ST_WINDOW:
          if (nseen == 3'(SEQ_LEN))
          begin
            // Killed parts never enter retest
            retest <= armed && pin_hist == RETEST_SEQ;
            state  <= ST_LOAD;
          end
          else if (tick)
          begin
            pin_hist <= {pin_hist[SEQ_LEN-2:0], pin_s2};
            nseen    <= nseen + 3'h1;
          end
        ST_LOAD:
          if (wcnt == 13'(LOAD_CYC - 1))
          begin
            wcnt  <= 13'h0000;
            state <= retest && armed && guard[BIT_RAM_WIPE]
                     ? ST_WRAM : ST_LOCK;
          end
          else
            wcnt <= wcnt + 13'h0001;
        ST_WRAM:
          if (wcnt == WIPE_LAST)
          begin
            wcnt  <= 13'(IRAM_KEEP);
            state <= ST_WIRAM;
          end
          else
            wcnt <= wcnt + 13'h0001;
        ST_WIRAM:
          if (wcnt == IRAM_LAST)
            state <= ST_LOCK;
          else
            wcnt <= wcnt + 13'h0001;
        ST_LOCK:
          state <= ST_DONE;
        ST_DONE:
          state <= ST_DONE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  // Wipe strobes follow the sequencer one cycle later
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ram_wipe_we_o   <= 1'b0;
      ram_wipe_iram_o <= 1'b0;
      ram_wipe_addr_o <= 13'h0000;
    end
    else
    begin
      ram_wipe_we_o   <= state == ST_WRAM || state == ST_WIRAM;
      ram_wipe_iram_o <= state == ST_WIRAM;
      ram_wipe_addr_o <= wcnt;
    end
  end

  // Locks: set at boot end, cleared only by device reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      eeprom_lock_o <= 1'b0;
      store_lock_o  <= 1'b0;
    end
    else if (state == ST_LOCK && retest && armed)
    begin
      if (guard[BIT_EEP_LOCK])
        eeprom_lock_o <= 1'b1;
      if (guard[BIT_STORE_LOCK])
        store_lock_o <= 1'b1;
    end
  end

  // Port and boot status
  always_ff @(posedge clk_i)
  begin
    if (rst_i || reboot)
    begin
      two_wire_debug_port_o <= 1'b0;
      boot_done_o           <= 1'b0;
      load_user_o           <= 1'b0;
    end
    else
    begin
      boot_done_o <= state == ST_DONE;
      // Only factory region loads on retest
      load_user_o <= state == ST_LOAD && !retest && level != LVL_FACTORY;
      // Open only after every guard action is done
      two_wire_debug_port_o <= state == ST_DONE
                               && (level != LVL_RUN || retest)
                               && !kill;
    end
  end

  assign boot_state_o = state; // Mirror for status
endmodule // rap_retest_guard

// ### verif/rap_retest_rig.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Retest equipment: pin pattern player and EEPROM cell
// ------------------------------------------------------------
module rap_retest_rig
(
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic       eep_wr_i,
  input  wire logic [7:0] eep_wdata_i,
  output logic            pin_o,
  output logic      [7:0] eep_rdata_o
);
  import rap_pkg::*;
  int         cnt = 0;     // Cycles left in the pattern
  logic [7:0] mem = 8'h3c; // Stored EEPROM byte
  // One pattern bit per sample period, oldest bit first
  always @(posedge clk_i)
  begin
    if (go_i)
      cnt <= SEQ_LEN * TICK_CYC;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // Outside a frame the pin rests low on its pull-down
  assign pin_o = (cnt > 0) ? RETEST_SEQ[(cnt - 1) / TICK_CYC] : 1'b0;
  // Cell takes each write pulse
  always @(posedge clk_i)
    if (eep_wr_i)
      mem <= eep_wdata_i;
  assign eep_rdata_o = mem;
endmodule // rap_retest_rig

// ### verif/rap_retest_guard_monitor.sv
`timescale 1ns/1ps
module rap_guard_monitor
#(
  parameter int RAM_BYTES = 4608, // Unified RAM size
  parameter int RAM_FACT  = 256   // Factory part at RAM end
)
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        eep_wr_o,
  input wire logic        two_wire_debug_port_o,
  input wire logic        ram_wipe_we_o,
  input wire logic        ram_wipe_iram_o,
  input wire logic [12:0] ram_wipe_addr_o,
  input wire logic        eeprom_lock_o,
  input wire logic        store_lock_o,
  input wire logic        boot_done_o
);
  import rap_pkg::*;
  // Single domain: one clocking, one disable
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_port_after_boot:
    assert property (two_wire_debug_port_o |-> boot_done_o)
    else $error("debug port open before boot end");
  a_wipe_port_shut:
    assert property (ram_wipe_we_o |-> !two_wire_debug_port_o && !boot_done_o)
    else $error("wipe while port open or boot done");
  a_lock_before_open:
    assert property ($rose(store_lock_o) |-> !two_wire_debug_port_o)
    else $error("store lock set after port opened");
  a_wipe_code_span:
    assert property (ram_wipe_we_o && !ram_wipe_iram_o
                     |-> int'(ram_wipe_addr_o) < RAM_BYTES - RAM_FACT)
    else $error("wipe reached factory part of RAM");
  a_wipe_iram_span:
    assert property (ram_wipe_we_o && ram_wipe_iram_o
                     |-> int'(ram_wipe_addr_o) >= IRAM_KEEP
                         && int'(ram_wipe_addr_o) < IRAM_BYTES)
    else $error("IRAM wipe outside its span");
  a_eep_lock_hold:
    assert property (eeprom_lock_o |=> eeprom_lock_o)
    else $error("EEPROM lock dropped");
  a_store_lock_hold:
    assert property (store_lock_o |=> store_lock_o)
    else $error("store lock dropped");
  a_eep_write_block:
    assert property (eeprom_lock_o |-> !eep_wr_o)
    else $error("EEPROM written while locked");
  a_eep_read_zero:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFS_EEP
                     && eeprom_lock_o |-> wb_dat_o == 32'h0)
    else $error("locked EEPROM read not zero");
  a_reboot_closes:
    assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                     && wb_adr_i == OFS_CTRL && wb_sel_i[0]
                     && wb_dat_i[BIT_REBOOT]
                     |=> !two_wire_debug_port_o && !boot_done_o)
    else $error("reboot left port open");
endmodule // rap_guard_monitor
bind rap_retest_guard rap_guard_monitor #(.RAM_BYTES(RAM_BYTES),
  .RAM_FACT(RAM_FACT)) mon (.*);

// ### verif/rap_retest_guard_tb.sv
`timescale 1ns/1ps
module rap_retest_guard_tb;
  import rap_pkg::*;
  localparam int RB = 300; // Small RAM keeps the wipe short
  localparam int RF = 32;  // Factory part of that RAM
  // Row: level and pattern in, then port, user load, locks out
  typedef struct {
    logic [1:0] lvl;
    logic       pat;
    logic       port;
    logic       ld;
    logic       lk;
  } rap_row_t;
  rap_row_t    rows [4] = '{'{2'h0, 1'b1, 1'b1, 1'b0, 1'b0},
                            '{2'h1, 1'b0, 1'b1, 1'b1, 1'b0},
                            '{2'h2, 1'b0, 1'b0, 1'b1, 1'b0},
                            '{2'h2, 1'b1, 1'b1, 1'b0, 1'b1}};
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, go = 1'b0, pin, ack, ew, port, ld, wwe, wir;
  logic        elk, slk, done;
  logic [3:0]  sel = 4'h1;
  logic [7:0]  adr = 8'h00, erd, ewd;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic [12:0] waddr;
  rap_state_t  st;
  int n_fail = 0, n_tests = 0, n_ld = 0, n_code = 0, n_iram = 0, n_ew = 0;
  int c0, i0, l0, e0;
  always #12.5 clk_i = ~clk_i;
  rap_retest_guard #(.RAM_BYTES(RB), .RAM_FACT(RF)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .retest_pin_i(pin),
    .eep_rdata_i(erd), .eep_wr_o(ew), .eep_wdata_o(ewd),
    .two_wire_debug_port_o(port), .load_user_o(ld),
    .ram_wipe_we_o(wwe), .ram_wipe_iram_o(wir), .ram_wipe_addr_o(waddr),
    .eeprom_lock_o(elk), .store_lock_o(slk), .boot_done_o(done),
    .boot_state_o(st));
  rap_retest_rig rig (.clk_i(clk_i), .go_i(go), .eep_wr_i(ew),
    .eep_wdata_i(ewd), .pin_o(pin), .eep_rdata_o(erd));
  // Event counters; tests compare their growth
  always @(posedge clk_i)
  begin
    if (ld) n_ld <= n_ld + 1;
    if (ew) n_ew <= n_ew + 1;
    if (wwe && wir) n_iram <= n_iram + 1;
    if (wwe && !wir) n_code <= n_code + 1;
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Classic cycle: hold until ack, then a cycle idle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    if (n >= 20) chk("ack", 32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd_store(input logic [7:0] a);
    wb(1'b1, OFS_SADDR, 32'(a));
    wb(1'b0, OFS_SDATA, 32'h0);
  endtask
  task wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("boot_done", 32'({done, 3'(st)}), 32'({1'b1, 3'(ST_DONE)}));
  endtask
  // Warm boot, optionally with the retest pattern
  task boot(input logic p);
    wb(1'b1, OFS_CTRL, 32'h1);
    go <= p;
    @(posedge clk_i);
    go <= 1'b0;
    wait_done();
  endtask
  task por;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("reset", 32'({port, elk, slk, done, ack, ew, wwe}), 32'h0);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wait_done();
  endtask
  // Reference checksum; user bytes carry an a5 mask
  function automatic logic [31:0] crc(input int lo, input int hi);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = lo; i <= hi; i++)
    begin
      c = c ^ 32'((i < 32) ? 8'(i) : 8'(i) ^ 8'ha5);
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction
  task crc_run(input logic [1:0] cmd);
    int n;
    wb(1'b1, OFS_CRCCMD, 32'(cmd));
    n = 0;
    do
    begin
      wb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (q[9] !== 1'b0 && n < 400);
    chk("crc_idle", 32'(q[9]), 32'h0);
    wb(1'b0, OFS_CRC, 32'h0);
  endtask
  task set_guard;
    wb(1'b1, OFS_PRIME, 32'h1);
    wb(1'b1, OFS_GUARD, 32'he0);
  endtask
  // Guard written too late, or port kill set in time
  task guard_phase(input logic late, input logic exp_port);
    por();
    if (!late) set_guard();
    wb(1'b1, OFS_LEVEL, 32'h1);
    wb(1'b1, OFS_LEVEL, 32'h2);
    if (late) set_guard();
    c0 = n_code;
    boot(1'b1);
    chk("phase_port", 32'(port), 32'(exp_port));
    chk("phase_lock", 32'({elk, slk}), 32'h0);
    chk("phase_wipe", 32'(n_code - c0), 32'h0);
    $display("guard phase late=%0d done", late);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // -----------------------------------------------------------
  // Main sequence: table of boots, then the awkward cases
  // -----------------------------------------------------------
  initial
  begin
    por();
    for (int i = 0; i < 32; i++)
    begin
      wb(1'b1, OFS_SADDR, 32'(i));
      wb(1'b1, OFS_SDATA, 32'(i));
    end
    wb(1'b1, OFS_SADDR, 32'd192);
    wb(1'b1, OFS_SDATA, 32'h5a);
    wb(1'b1, OFS_GUARD, 32'he0);
    wb(1'b1, OFS_EEP, 32'h77);
    wb(1'b0, OFS_EEP, 32'h0);
    chk("eep_open", q, 32'h77);
    for (int j = 0; j < 4; j++)
    begin
      if (j > 0 && rows[j].lvl != rows[j-1].lvl)
        wb(1'b1, OFS_LEVEL, 32'(rows[j].lvl));
      if (rows[j].lvl == 2'h1)
      begin
        // Append one byte past the free space
        for (int i = 32; i <= 192; i++)
          wb(1'b1, OFS_SDATA, 32'(8'(i) ^ 8'ha5));
        rd_store(8'd100);
        chk("append", q, 32'(8'd100 ^ 8'ha5));
        rd_store(8'd192);
        chk("full", q, 32'h5a);
      end
      l0 = n_ld;
      c0 = n_code;
      i0 = n_iram;
      boot(rows[j].pat);
      chk("port", 32'(port), 32'(rows[j].port));
      chk("user_load", 32'(n_ld > l0), 32'(rows[j].ld));
      chk("eep_lock", 32'(elk), 32'(rows[j].lk));
      chk("store_lock", 32'(slk), 32'(rows[j].lk));
      chk("wipe_code", 32'(n_code - c0), rows[j].lk ? RB - RF : 0);
      chk("wipe_iram", 32'(n_iram - i0), rows[j].lk ? 248 : 0);
      $display("boot row %0d done", j);
    end
    wb(1'b0, OFS_EEP, 32'h0);
    chk("eep_read", q, 32'h0);
    e0 = n_ew;
    wb(1'b1, OFS_EEP, 32'h77);
    chk("eep_write", 32'(n_ew - e0), 32'h0);
    wb(1'b1, OFS_SDATA, 32'h11);
    wb(1'b0, OFS_SDATA, 32'h0);
    chk("tail", q, 32'h5a);
    rd_store(8'd5);
    chk("refuse", q, 32'h0);
    crc_run(CRC_FACTORY);
    chk("crc_factory", q, crc(0, 31));
    crc_run(CRC_USER);
    chk("crc_user", q, crc(32, 191));
    boot(1'b0);
    chk("warm_keep", 32'({elk, slk, port}), 32'h6);
    $display("locked access done");
    guard_phase(1'b1, 1'b1);
    guard_phase(1'b0, 1'b0);
    wrap_up();
  end
  // Tests need about 4k cycles; ten times that
  initial
  begin
    #1000000;
    n_fail++;
    $display("MISMATCH watchdog exp finish got hang");
    wrap_up();
  end
endmodule // rap_retest_guard_tb
